/* File: rtl/sdc_loader.sv */
// configuration loader and dividers of the frequency synthesizer
// Overview of operation
// - divider reset clears dividers, forces outputs
// - divider reset keeps loaded settings
// - serial clock rise shifts serial data in
// - source select high picks crystal reference
// - bypass select low bypasses the PLL
// - parallel strobe low passes pins, monitor low
// - parallel strobe rise latches pin values
// - transfer strobe rise copies shift register
// - transfer strobe fall freezes divider settings
// - transfer strobe high passes shifted data through
// - feedback value is nine-bit unsigned binary
// - output code selects ratio one to twelve
// - output divider keeps fifty percent duty
// - test bits select monitor source
// - reference divided by sixteen before comparison
`timescale 1ns/1ps
module sdc_loader (
  input  wire logic                     clk,                      // 125 MHz clock
  input  wire logic                     arst_n,                   // async reset, active low
  input  wire logic                     divider_reset,            // pin, active high
  input  wire logic                     parallel_latch_strobe_n,  // pin, active low
  input  wire logic [sdc_pkg::FB_W-1:0] feedback_divide_bits,     // parallel feedback value
  input  wire logic [sdc_pkg::OD_W-1:0] output_divide_code,       // parallel output code
  input  wire logic                     serial_clock,             // serial shift clock pin
  input  wire logic                     serial_data,              // serial data pin
  input  wire logic                     serial_load,              // serial transfer strobe
  input  wire logic                     ref_source_select,        // 1 crystal, 0 ref clock
  input  wire logic                     pll_bypass_select,        // 0 bypass, 1 PLL
  input  wire logic                     xtal_clk,                 // crystal oscillator level
  input  wire logic                     ref_clk,                  // single-ended reference
  output logic                          synth_out_true_q,         // true output
  output logic                          synth_out_inverted_q,     // inverted output
  output logic                          test_monitor_q,           // test monitor output
  output logic                          ref_div_q,                // reference divided by 16
  output logic                          fb_div_q,                 // feedback divider output
  output logic                          pll_mode_q,               // 1 PLL mode, 0 bypass
  output logic                          xtal_ref_q,               // 1 crystal reference
  output logic [sdc_pkg::FB_W-1:0]      fb_value_q,               // active feedback value
  output logic [sdc_pkg::OD_W-1:0]      od_code_q,                // active output code
  output logic [1:0]                    mon_sel_q                 // active test-select bits
);
  localparam int PIN_W = 21;

  // two-flop synchronisers for every pin
  logic [PIN_W-1:0] s1_q;
  logic [PIN_W-1:0] s2_q;
  wire  [PIN_W-1:0] pins = {divider_reset, parallel_latch_strobe_n, feedback_divide_bits,
                            output_divide_code, serial_clock, serial_data, serial_load,
                            ref_source_select, pll_bypass_select, xtal_clk, ref_clk};
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
    end
  end

  wire                     mr    = s2_q[20];
  wire                     pl_n  = s2_q[19];
  wire [sdc_pkg::FB_W-1:0] p_fb  = s2_q[18:10];
  wire [sdc_pkg::OD_W-1:0] p_od  = s2_q[9:7];
  wire                     sck   = s2_q[6];
  wire                     sdat  = s2_q[5];
  wire                     sld   = s2_q[4];
  wire                     xsel  = s2_q[3];
  wire                     vsel  = s2_q[2];
  wire                     xclk  = s2_q[1];
  wire                     rclk  = s2_q[0];

  // edge detection on synchronised levels
  logic sck_q;
  logic sld_q;
  logic refsrc_q;
  wire  refsrc   = xsel ? xclk : rclk;
  wire  sck_rise = sck & ~sck_q;
  wire  sld_rise = sld & ~sld_q;
  wire  ref_rise = refsrc & ~refsrc_q;
  wire  ser_mode = pl_n;

  // shift register, first bit ends at the top
  logic [sdc_pkg::SR_W-1:0] sr_q;
  wire  [sdc_pkg::SR_W-1:0] sr_next = {sr_q[sdc_pkg::SR_W-2:0], sdat};
  wire  shift_en = ser_mode & sck_rise;

  wire  par_pass = ~pl_n;
  wire  ser_xfer = ser_mode & sld_rise;
  wire  ser_thru = ser_mode & sld & sld_q & shift_en;
  wire  [sdc_pkg::SR_W-1:0] ld_src = ser_thru ? sr_next : sr_q;

  logic [sdc_pkg::FB_W-1:0] fb_value_d;
  logic [sdc_pkg::OD_W-1:0] od_code_d;
  logic [1:0]               mon_sel_d;
  always_comb begin
    fb_value_d = fb_value_q;
    od_code_d  = od_code_q;
    mon_sel_d  = mon_sel_q;
    if (par_pass) begin
      fb_value_d = p_fb;
      od_code_d  = p_od;
    end else if (ser_xfer || ser_thru) begin
      fb_value_d = ld_src[sdc_pkg::SR_FB_LSB +: sdc_pkg::FB_W];
      od_code_d  = ld_src[sdc_pkg::SR_OD_LSB +: sdc_pkg::OD_W];
      mon_sel_d  = ld_src[sdc_pkg::SR_TS_LSB +: 2];
    end
    // a falling transfer strobe leaves the settings frozen
  end

  // edge history starts at the idle pin levels, so reset makes no false edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sck_q    <= 1'b0;
      sld_q    <= 1'b0;
      refsrc_q <= 1'b0;
    end else begin
      sck_q    <= sck;
      sld_q    <= sld;
      refsrc_q <= refsrc;
    end
  end

  // shift register moves only on a serial clock rise in serial mode
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sr_q <= '0;
    end else begin
      sr_q <= shift_en ? sr_next : sr_q;
    end
  end

  // settings ignore the divider reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fb_value_q <= sdc_pkg::FB_RST;
      od_code_q  <= sdc_pkg::OD_RST;
      mon_sel_q  <= sdc_pkg::MON_LOW;
    end else begin
      fb_value_q <= fb_value_d;
      od_code_q  <= od_code_d;
      mon_sel_q  <= mon_sel_d;
    end
  end

  // reference pre-divider
  logic [3:0] ref_cnt_q;
  wire        ref_wrap = ref_cnt_q == 4'(sdc_pkg::REF_DIV - 1);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_cnt_q <= '0;
      ref_div_q <= 1'b0;
    end else if (mr) begin
      ref_cnt_q <= '0;
      ref_div_q <= 1'b0;
    end else if (ref_rise) begin
      ref_cnt_q <= ref_wrap ? 4'h0 : ref_cnt_q + 4'h1;
      ref_div_q <= ref_cnt_q < 4'(sdc_pkg::REF_DIV / 2 - 1) || ref_wrap;
    end
  end

  // feedback divider, high for the first half of each period
  logic [sdc_pkg::FB_W-1:0] fb_cnt_q;
  wire  [sdc_pkg::FB_W-1:0] fb_last = (fb_value_q == '0) ? '0 : fb_value_q - 9'h001;
  wire  [sdc_pkg::FB_W-1:0] fb_cnt_n = (fb_cnt_q >= fb_last) ? '0 : fb_cnt_q + 9'h001;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fb_cnt_q <= '0;
      fb_div_q <= 1'b0;
    end else if (mr) begin
      fb_cnt_q <= '0;
      fb_div_q <= 1'b0;
    end else begin
      fb_cnt_q <= fb_cnt_n;
      fb_div_q <= fb_cnt_n < (fb_value_q >> 1) || fb_value_q == 9'h001;
    end
  end

  // output divider runs on the VCO stand-in or on the reference in bypass
  wire  od_tick = vsel ? 1'b1 : ref_rise;
  logic od_phase;
  sdc_out_divider u_od (
    .clk     (clk),
    .arst_n  (arst_n),
    .hold    (mr),
    .tick    (od_tick),
    .code    (od_code_q),
    .phase_q (od_phase)
  );

  logic mon_d;
  always_comb begin
    mon_d = 1'b0;
    if (ser_mode) begin
      unique case (mon_sel_q)
        sdc_pkg::MON_SDAT: mon_d = sdat;
        sdc_pkg::MON_FB:   mon_d = fb_div_q;
        default:           mon_d = 1'b0;
      endcase
    end
  end

  // output pair: the divider reset wins over the divider phase
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      synth_out_true_q     <= 1'b0;
      synth_out_inverted_q <= 1'b1;
      test_monitor_q       <= 1'b0;
    end else begin
      synth_out_true_q     <= ~mr & od_phase;
      synth_out_inverted_q <= mr | ~od_phase;
      test_monitor_q       <= mon_d;
    end
  end

  // registered copies of the mode pins for the analog side
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pll_mode_q <= 1'b0;
      xtal_ref_q <= 1'b0;
    end else begin
      pll_mode_q <= vsel;
      xtal_ref_q <= xsel;
    end
  end
endmodule : sdc_loader

/* File: rtl/sdc_pkg.sv */
// shared constants of the synthesizer divider configuration loader
package sdc_pkg;
  localparam int FB_W      = 9;
  localparam int OD_W      = 3;
  localparam int SR_W      = 14;
  localparam int SR_FB_LSB = 0;
  localparam int SR_OD_LSB = 9;
  localparam int SR_TS_LSB = 12;
  localparam int REF_DIV   = 16;
  localparam int HALF_W    = 5;
  localparam logic [1:0] MON_LOW  = 2'h0;
  localparam logic [1:0] MON_SDAT = 2'h1;
  localparam logic [1:0] MON_FB   = 2'h2;
  localparam logic [FB_W-1:0] FB_RST = 9'h000;
  localparam logic [OD_W-1:0] OD_RST = 3'h0;

  // half period in clk ticks; clk ticks stand for quarter VCO periods
  function automatic logic [HALF_W-1:0] sdc_half_period(input logic [OD_W-1:0] code);
    logic [HALF_W-1:0] h;
    h = 5'h02;
    unique case (code)
      3'h0: h = 5'h02;
      3'h1: h = 5'h03;
      3'h2: h = 5'h04;
      3'h3: h = 5'h06;
      3'h4: h = 5'h08;
      3'h5: h = 5'h0c;
      3'h6: h = 5'h10;
      3'h7: h = 5'h18;
    endcase
    return h;
  endfunction : sdc_half_period
endpackage : sdc_pkg

/* File: rtl/sdc_out_divider.sv */
// output divider with even half periods for every ratio
`timescale 1ns/1ps
module sdc_out_divider (
  input  wire logic                        clk,      // system clock
  input  wire logic                        arst_n,   // async reset, active low
  input  wire logic                        hold,     // divider held in reset
  input  wire logic                        tick,     // source advance
  input  wire logic [sdc_pkg::OD_W-1:0]    code,     // output divide code
  output logic                             phase_q   // divided phase
);
  logic [sdc_pkg::HALF_W-1:0] cnt_q;
  logic [sdc_pkg::HALF_W-1:0] cnt_d;
  logic                       phase_d;
  wire  [sdc_pkg::HALF_W-1:0] half = sdc_pkg::sdc_half_period(code);
  wire                        wrap = (cnt_q + 5'h01) >= half;

  always_comb begin
    cnt_d   = cnt_q;
    phase_d = phase_q;
    if (hold) begin
      cnt_d   = '0;
      phase_d = 1'b0;
    end else if (tick) begin
      cnt_d   = wrap ? '0 : cnt_q + 5'h01;
      phase_d = wrap ? ~phase_q : phase_q;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q   <= '0;
      phase_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      phase_q <= phase_d;
    end
  end
endmodule : sdc_out_divider

/* File: tb/sdc_ctl_model.sv */
// board controller model that shifts serial words into the loader
`timescale 1ns/1ps
module sdc_ctl_model (
  input  wire logic clk,          // system clock
  output logic      serial_clock, // shift clock, idle low
  output logic      serial_data   // shift data
);
  initial begin
    serial_clock = 1'b0;
    serial_data  = 1'b0;
  end
  // each level held 4 clk so the 2-flop sampler sees it
  task automatic send(input logic [13:0] word);
    for (int i = 13; i >= 0; i--) begin
      @(posedge clk);
      #1 serial_data = word[i];
      repeat (4) @(posedge clk);
      #1 serial_clock = 1'b1;
      repeat (4) @(posedge clk);
      #1 serial_clock = 1'b0;
      serial_data = ~word[i];
    end
    repeat (4) @(posedge clk);
    #1;
  endtask : send
endmodule : sdc_ctl_model

/* File: tb/sdc_loader_props.sv */
// assertions on the loader ports
`timescale 1ns/1ps
module sdc_loader_props (
  input wire logic       clk,                      // system clock
  input wire logic       arst_n,                   // async reset, active low
  input wire logic       divider_reset,            // divider reset pin
  input wire logic       parallel_latch_strobe_n,  // parallel strobe pin
  input wire logic [8:0] feedback_divide_bits,     // parallel feedback pins
  input wire logic [2:0] output_divide_code,       // parallel output code pins
  input wire logic       serial_load,              // transfer strobe pin
  input wire logic       ref_source_select,        // reference select pin
  input wire logic       pll_bypass_select,        // bypass select pin
  input wire logic       synth_out_true_q,         // true output
  input wire logic       synth_out_inverted_q,     // inverted output
  input wire logic       test_monitor_q,           // test monitor output
  input wire logic       ref_div_q,                // divided reference
  input wire logic       fb_div_q,                 // feedback divider output
  input wire logic       pll_mode_q,               // synced bypass select
  input wire logic       xtal_ref_q,               // synced source select
  input wire logic [8:0] fb_value_q,               // active feedback value
  input wire logic [2:0] od_code_q,                // active output code
  input wire logic [1:0] mon_sel_q                 // active test-select bits
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_reset_forces_out: assert property (
    divider_reset [*4] |=> !synth_out_true_q && synth_out_inverted_q) else $error("out not forced");
  a_reset_div_low: assert property (
    divider_reset [*4] |=> !fb_div_q && !ref_div_q) else $error("dividers not held");
  a_out_complement: assert property (
    synth_out_inverted_q != synth_out_true_q) else $error("outputs not complementary");
  a_settings_hold: assert property (
    (parallel_latch_strobe_n && !serial_load) [*5] |=> $stable(fb_value_q) && $stable(od_code_q))
    else $error("settings moved");
  a_par_pass: assert property (
    (!parallel_latch_strobe_n && $stable(feedback_divide_bits) && $stable(output_divide_code)) [*5]
    |-> fb_value_q == feedback_divide_bits && od_code_q == output_divide_code)
    else $error("pins not passed");
  a_par_mon_low: assert property (
    !parallel_latch_strobe_n [*6] |-> !test_monitor_q) else $error("monitor not low");
  a_src_select: assert property (
    $stable(ref_source_select) [*5] |-> xtal_ref_q == ref_source_select) else $error("source");
  a_bypass_select: assert property (
    $stable(pll_bypass_select) [*5] |-> pll_mode_q == pll_bypass_select) else $error("bypass");
  a_mon_fb_follow: assert property (
    (parallel_latch_strobe_n && mon_sel_q == 2'h2) [*4] |-> test_monitor_q == $past(fb_div_q))
    else $error("monitor not following feedback divider");
endmodule : sdc_loader_props
bind sdc_loader sdc_loader_props u_sdc_loader_props (.*);

/* File: tb/sdc_loader_tb_top.sv */
// self-checking bench of the configuration loader
`timescale 1ns/1ps
module sdc_loader_tb_top;
  logic       clk = 1'b0, arst_n = 1'b0, div_rst = 1'b0, strobe_n = 1'b0, s_load = 1'b0;
  logic       ref_sel = 1'b0, pll_sel = 1'b0, xtal = 1'b0, refc = 1'b0, s_clk, s_dat;
  logic [8:0] fb_pins = 9'h000, fb_val;
  logic [2:0] od_pins = 3'h0, od_val;
  logic [1:0] mon_sel;
  logic       out_t, out_n, mon, ref_div, fb_div, pll_mode, xtal_ref;
  int         err_total = 0, checked = 0, hi, lo;
  int         half [8] = '{2, 3, 4, 6, 8, 12, 16, 24};
  always #4 clk = ~clk;
  always #40 xtal = ~xtal;
  always #56 refc = ~refc;
  sdc_ctl_model u_sdc_ctl_model (.clk(clk), .serial_clock(s_clk), .serial_data(s_dat));
  sdc_loader u_sdc_loader (.clk(clk), .arst_n(arst_n), .divider_reset(div_rst),
    .parallel_latch_strobe_n(strobe_n), .feedback_divide_bits(fb_pins),
    .output_divide_code(od_pins), .serial_clock(s_clk), .serial_data(s_dat),
    .serial_load(s_load), .ref_source_select(ref_sel), .pll_bypass_select(pll_sel),
    .xtal_clk(xtal), .ref_clk(refc), .synth_out_true_q(out_t), .synth_out_inverted_q(out_n),
    .test_monitor_q(mon), .ref_div_q(ref_div), .fb_div_q(fb_div), .pll_mode_q(pll_mode),
    .xtal_ref_q(xtal_ref), .fb_value_q(fb_val), .od_code_q(od_val), .mon_sel_q(mon_sel));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  function automatic logic sig(input logic [1:0] sel);
    return sel == 2'h0 ? out_t : sel == 2'h1 ? fb_div : sel == 2'h2 ? mon : ref_div;
  endfunction : sig
  // waits for a fresh rising edge, then counts the high and low spans
  task automatic duty(input logic [1:0] sel);
    for (int i = 0; i < 600 && sig(sel) !== 1'b0; i++) tick(1);
    for (int i = 0; i < 600 && sig(sel) !== 1'b1; i++) tick(1);
    for (hi = 0; hi < 600 && sig(sel) === 1'b1; hi++) tick(1);
    for (lo = 0; lo < 600 && sig(sel) === 1'b0; lo++) tick(1);
  endtask : duty
  task automatic test_done();
    $display("Checks %0d, errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  initial begin
    #200000;
    err_total++;
    test_done();
  end
  initial begin
    tick(2);
    arst_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      {ref_sel, pll_sel} = i[1:0];
      tick(6);
      chk({xtal_ref, pll_mode}, i[1:0]);
    end
    fb_pins = 9'h0fa;
    for (int c = 0; c < 8; c++) begin
      od_pins = c[2:0];
      tick(6);
      chk(od_val, c[2:0]);
      duty(2'h0);
      chk(hi, half[c]);
      chk(lo, half[c]);
    end
    chk(fb_val, 9'h0fa);
    chk(mon, 1'b0);
    duty(2'h1);
    chk(hi, 125);
    chk(lo, 125);
    strobe_n = 1'b1;
    tick(6);
    fb_pins = 9'h1f4;
    tick(6);
    chk(fb_val, 9'h0fa);
    u_sdc_ctl_model.send({2'b00, 3'h3, 9'h1f4});
    chk(fb_val, 9'h0fa);
    s_load = 1'b1;
    tick(6);
    chk({mon_sel, od_val, fb_val}, {2'b00, 3'h3, 9'h1f4});
    s_load = 1'b0;
    tick(6);
    u_sdc_ctl_model.send({2'b01, 3'h1, 9'h0ff});
    chk(fb_val, 9'h1f4);
    div_rst = 1'b1;
    tick(8);
    chk({out_t, out_n, fb_div, ref_div}, 4'b0100);
    chk(fb_val, 9'h1f4);
    div_rst = 1'b0;
    s_load = 1'b1;
    tick(6);
    u_sdc_ctl_model.send({2'b10, 3'h2, 9'h0fb});
    chk({mon_sel, od_val, fb_val}, {2'b10, 3'h2, 9'h0fb});
    duty(2'h1);
    chk(hi, 125);
    chk(lo, 126);
    duty(2'h2);
    chk(hi, 125);
    chk(lo, 126);
    s_load = 1'b0;
    tick(6);
    u_sdc_ctl_model.send({2'b01, 3'h2, 9'h0fa});
    s_load = 1'b1;
    tick(6);
    chk({mon_sel, od_val, fb_val}, {2'b01, 3'h2, 9'h0fa});
    chk({mon, s_dat}, 2'b11);
    duty(2'h3);
    chk(hi, 80);
    chk(lo, 80);
    pll_sel = 1'b0;
    tick(6);
    duty(2'h0);
    chk(hi, 40);
    chk(lo, 40);
    ref_sel = 1'b0;
    tick(6);
    duty(2'h3);
    chk(hi, 112);
    chk(lo, 112);
    test_done();
  end
endmodule : sdc_loader_tb_top
